// ===== rtl/uart_ctl_pkg.sv
// constants and carrier types for the uart interrupt and fifo control slice
package uart_ctl_pkg;

    // ------------------------------------------------------------
    // register offsets and line control decode
    // ------------------------------------------------------------
    localparam logic [3:0] OFF_INT_ENABLE = 4'h1;
    localparam logic [3:0] OFF_ID_FIFO    = 4'h2;
    localparam int         LC_LATCH_BIT   = 7;
    localparam logic [7:0] LC_ENH_ACCESS  = 8'hbf;
    localparam int         EF_ENH_BIT     = 4;

    // ------------------------------------------------------------
    // interrupt enable field positions
    // ------------------------------------------------------------
    localparam int IE_RX_DATA  = 0;
    localparam int IE_TX_READY = 1;
    localparam int IE_LINE     = 2;
    localparam int IE_MODEM    = 3;
    localparam int IE_SLEEP    = 4;
    localparam int IE_SWFLOW   = 5;
    localparam int IE_RTS_DTR  = 6;
    localparam int IE_CTS_DSR  = 7;

    // ------------------------------------------------------------
    // fifo setup field positions
    // ------------------------------------------------------------
    localparam int FS_ENABLE   = 0;
    localparam int FS_RX_CLR   = 1;
    localparam int FS_TX_CLR   = 2;
    localparam int FS_TX_TRG_L = 4;
    localparam int FS_RX_TRG_L = 6;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] IE_RESET  = 8'h00;
    localparam logic [7:0] DIV_RESET = 8'h00;
    localparam logic [7:0] ID_RESET  = 8'h01;
    localparam logic [1:0] TRG_RESET = 2'h0;

    // ------------------------------------------------------------
    // identification codes, bits 5:0, highest priority first
    // ------------------------------------------------------------
    localparam logic [5:0] ID_NONE    = 6'h01;
    localparam logic [5:0] ID_LINE    = 6'h06;
    localparam logic [5:0] ID_RX_TOUT = 6'h0c;
    localparam logic [5:0] ID_RX_DATA = 6'h04;
    localparam logic [5:0] ID_TX_RDY  = 6'h02;
    localparam logic [5:0] ID_MODEM   = 6'h00;
    localparam logic [5:0] ID_PIN_CHG = 6'h30;
    localparam logic [5:0] ID_SWFLOW  = 6'h10;
    localparam logic [5:0] ID_CTS_RTS = 6'h20;

    // ------------------------------------------------------------
    // trigger levels in characters / free spaces
    // ------------------------------------------------------------
    localparam logic [6:0] RX_TRG_0 = 7'h08;
    localparam logic [6:0] RX_TRG_1 = 7'h10;
    localparam logic [6:0] RX_TRG_2 = 7'h38;
    localparam logic [6:0] RX_TRG_3 = 7'h3c;
    localparam logic [6:0] TX_TRG_0 = 7'h08;
    localparam logic [6:0] TX_TRG_1 = 7'h10;
    localparam logic [6:0] TX_TRG_2 = 7'h20;
    localparam logic [6:0] TX_TRG_3 = 7'h38;
    localparam logic [6:0] TRG_NOFIFO = 7'h01;

    // status from the serial engines, same clock
    typedef struct packed {
        logic line_err;
        logic rx_timeout;
        logic hold_empty;
        logic modem_chg;
        logic pin_chg;
        logic xoff_det;
        logic xon_det;
        logic spec_det;
        logic cts_inact;
        logic rts_inact;
        logic tx_empty;
        logic rx_empty;
    } engine_status_t;

    // channel power state
    typedef enum logic [0:0] {
        PWR_AWAKE  = 1'b0,
        PWR_ASLEEP = 1'b1
    } power_state_t;

endpackage

// ===== rtl/irq_priority.sv
// priority encoder from enabled pending sources to an identification code
`timescale 1ns/1ps
`default_nettype none
module irq_priority (
    // enabled pending sources, bit 0 highest priority
    input  wire logic [8:0] pend,
    // code for bits 5:0 of the identification register
    output logic      [5:0] code
);

    // scan from lowest to highest so the highest priority wins
    always_comb begin
        code = uart_ctl_pkg::ID_NONE;
        for (int i = 8; i >= 0; i--) begin
            if (pend[i]) begin
                case (i)
                    0:       code = uart_ctl_pkg::ID_LINE;
                    1:       code = uart_ctl_pkg::ID_RX_TOUT;
                    2:       code = uart_ctl_pkg::ID_RX_DATA;
                    3:       code = uart_ctl_pkg::ID_TX_RDY;
                    4:       code = uart_ctl_pkg::ID_MODEM;
                    5:       code = uart_ctl_pkg::ID_PIN_CHG;
                    6:       code = uart_ctl_pkg::ID_SWFLOW;
                    default: code = uart_ctl_pkg::ID_CTS_RTS;
                endcase
            end
        end
    end

endmodule
`default_nettype wire

// ===== rtl/uart_irq_fifo_control.sv
// uart channel interrupt enable, divisor high, id, fifo setup and sleep
//
// Operation
// - enable register at 1 when latch select clear
// - bits 7,6,5 enable cts, rts, flow interrupts
// - enable bits 7:4 writable only with enhanced
// - sleep only when idle, steady, empty, quiet
// - modem toggle, rx low, tx write wake
// - oscillator stopped while asleep
// - tx ready on empty or space above trigger
// - bits 3,2,0 enable modem, line, rx data
// - divisor high at 1, cleared by power-on only
// - bit 0 low when pending; priority 1-3 codes
// - codes for priorities 4 to 7
// - flow bit clears by xon or read
// - fifo setup bits 7:6 rx trigger
// - fifo setup bits 5:4 tx trigger
// - bit 2 clears tx fifo, self clears
// - bit 1 clears rx fifo, self clears
// - bit 0 enables 64 deep fifos
// - tx trigger writable only with enhanced
// - latch select moves offset 1 to divisor, except at bf
`timescale 1ns/1ps
`default_nettype none
module uart_irq_fifo_control #(
    parameter int FIFO_DEPTH = 64
) (
    // clock and resets
    input  wire logic                         mclk,
    input  wire logic                         rstn,
    input  wire logic                         soft_rst,
    // register port
    input  wire logic [3:0]                   reg_addr,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    input  wire logic [7:0]                   reg_wdata,
    output logic      [7:0]                   reg_rdata_q,
    // neighbouring control registers
    input  wire logic [7:0]                   line_control,
    input  wire logic [7:0]                   enhanced_feature,
    // serial engine status
    input  wire uart_ctl_pkg::engine_status_t eng,
    input  wire logic [6:0]                   rx_level,
    input  wire logic [6:0]                   tx_free,
    input  wire logic                         hold_write,
    // pins
    input  wire logic                         rx_pin,
    input  wire logic [3:0]                   modem_pins,
    // control outputs
    output logic      [7:0]                   interrupt_enable_q,
    output logic      [7:0]                   baud_divisor_high_q,
    output logic      [7:0]                   interrupt_source_id_q,
    output logic                              fifo_en_q,
    output logic      [6:0]                   rx_trig_q,
    output logic      [6:0]                   tx_trig_q,
    output logic                              tx_fifo_clr_q,
    output logic                              rx_fifo_clr_q,
    output logic                              irq_n_q,
    output logic                              osc_stop_q
);

    // ------------------------------------------------------------
    // access decode
    // ------------------------------------------------------------
    logic       dlab;
    logic       enh;
    logic       wr_ie;
    logic       wr_div;
    logic       wr_fs;
    logic       rd_id;
    logic [1:0] rx_sel_q;
    logic [1:0] tx_sel_q;

    assign dlab   = line_control[uart_ctl_pkg::LC_LATCH_BIT];
    assign enh    = enhanced_feature[uart_ctl_pkg::EF_ENH_BIT];
    assign wr_ie  = reg_wr && reg_addr == uart_ctl_pkg::OFF_INT_ENABLE
                    && !dlab;
    assign wr_div = reg_wr && reg_addr == uart_ctl_pkg::OFF_INT_ENABLE
                    && dlab
                    && line_control != uart_ctl_pkg::LC_ENH_ACCESS;
    assign wr_fs  = reg_wr && reg_addr == uart_ctl_pkg::OFF_ID_FIFO
                    && !dlab;
    assign rd_id  = reg_rd && reg_addr == uart_ctl_pkg::OFF_ID_FIFO && !dlab;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_s1_q;
    logic [4:0] pin_s2_q;
    logic [4:0] pin_s3_q;
    logic       modem_toggle;
    logic       rx_idle;

    // s3 is history for toggle detection, s1 feeds only s2
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pin_s1_q <= 5'h1f;
            pin_s2_q <= 5'h1f;
            pin_s3_q <= 5'h1f;
        end else begin
            pin_s1_q <= {rx_pin, modem_pins};
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
        end
    end

    assign modem_toggle = |(pin_s2_q[3:0] ^ pin_s3_q[3:0]);
    assign rx_idle      = pin_s2_q[4];

    // ------------------------------------------------------------
    // interrupt enable register
    // ------------------------------------------------------------
    // upper nibble frozen unless enhanced functions are on
    always_ff @(posedge mclk) begin
        if (!rstn || soft_rst) begin
            interrupt_enable_q <= uart_ctl_pkg::IE_RESET;
        end else if (wr_ie) begin
            interrupt_enable_q[3:0] <= reg_wdata[3:0];
            if (enh) begin
                interrupt_enable_q[7:4] <= reg_wdata[7:4];
            end
        end
    end

    // ------------------------------------------------------------
    // divisor high byte
    // ------------------------------------------------------------
    // survives software reset so the baud rate holds
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            baud_divisor_high_q <= uart_ctl_pkg::DIV_RESET;
        end else if (wr_div) begin
            baud_divisor_high_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // fifo setup register, write only
    // ------------------------------------------------------------
    // with bit 0 clear the trigger fields are not programmable
    always_ff @(posedge mclk) begin
        if (!rstn || soft_rst) begin
            fifo_en_q <= 1'b0;
            rx_sel_q  <= uart_ctl_pkg::TRG_RESET;
            tx_sel_q  <= uart_ctl_pkg::TRG_RESET;
        end else if (wr_fs) begin
            fifo_en_q <= reg_wdata[uart_ctl_pkg::FS_ENABLE];
            if (reg_wdata[uart_ctl_pkg::FS_ENABLE]) begin
                rx_sel_q <= reg_wdata[uart_ctl_pkg::FS_RX_TRG_L +: 2];
                if (enh) begin
                    tx_sel_q <= reg_wdata[uart_ctl_pkg::FS_TX_TRG_L +: 2];
                end
            end
        end
    end

    // clear strobes are one-cycle pulses, the bits never store
    always_ff @(posedge mclk) begin
        if (!rstn || soft_rst) begin
            tx_fifo_clr_q <= 1'b0;
            rx_fifo_clr_q <= 1'b0;
        end else begin
            tx_fifo_clr_q <= wr_fs && reg_wdata[uart_ctl_pkg::FS_TX_CLR];
            rx_fifo_clr_q <= wr_fs && reg_wdata[uart_ctl_pkg::FS_RX_CLR];
        end
    end

    // trigger decode registered so outputs come from flops
    always_ff @(posedge mclk) begin
        if (!rstn || soft_rst) begin
            rx_trig_q <= uart_ctl_pkg::TRG_NOFIFO;
            tx_trig_q <= uart_ctl_pkg::TRG_NOFIFO;
        end else if (!fifo_en_q) begin
            rx_trig_q <= uart_ctl_pkg::TRG_NOFIFO;
            tx_trig_q <= uart_ctl_pkg::TRG_NOFIFO;
        end else begin
            case (rx_sel_q)
                2'h0:    rx_trig_q <= uart_ctl_pkg::RX_TRG_0;
                2'h1:    rx_trig_q <= uart_ctl_pkg::RX_TRG_1;
                2'h2:    rx_trig_q <= uart_ctl_pkg::RX_TRG_2;
                default: rx_trig_q <= uart_ctl_pkg::RX_TRG_3;
            endcase
            case (tx_sel_q)
                2'h0:    tx_trig_q <= uart_ctl_pkg::TX_TRG_0;
                2'h1:    tx_trig_q <= uart_ctl_pkg::TX_TRG_1;
                2'h2:    tx_trig_q <= uart_ctl_pkg::TX_TRG_2;
                default: tx_trig_q <= uart_ctl_pkg::TX_TRG_3;
            endcase
        end
    end

    // ------------------------------------------------------------
    // software flow flags behind identification bit 4
    // ------------------------------------------------------------
    logic xoff_flag_q;
    logic spec_flag_q;

    // a new detection in the clearing cycle wins
    always_ff @(posedge mclk) begin
        if (!rstn || soft_rst) begin
            xoff_flag_q <= 1'b0;
            spec_flag_q <= 1'b0;
        end else begin
            if (eng.xoff_det) begin
                xoff_flag_q <= 1'b1;
            end else if (eng.xon_det) begin
                xoff_flag_q <= 1'b0;
            end
            if (eng.spec_det) begin
                spec_flag_q <= 1'b1;
            end else if (rd_id) begin
                spec_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // source gating and priority
    // ------------------------------------------------------------
    logic       rx_ready;
    logic       tx_ready;
    logic [8:0] pend;
    logic [5:0] code;

    // without fifos the level trigger collapses to one character
    assign rx_ready = !eng.rx_empty && rx_level >= rx_trig_q;
    assign tx_ready = fifo_en_q ? tx_free > tx_trig_q
                                : eng.hold_empty;

    // gating keeps disabled sources out of id and output
    assign pend[0] = eng.line_err   && interrupt_enable_q[uart_ctl_pkg::IE_LINE];
    assign pend[1] = eng.rx_timeout && interrupt_enable_q[uart_ctl_pkg::IE_RX_DATA];
    assign pend[2] = rx_ready       && interrupt_enable_q[uart_ctl_pkg::IE_RX_DATA];
    assign pend[3] = tx_ready       && interrupt_enable_q[uart_ctl_pkg::IE_TX_READY];
    assign pend[4] = eng.modem_chg  && interrupt_enable_q[uart_ctl_pkg::IE_MODEM];
    assign pend[5] = eng.pin_chg    && interrupt_enable_q[uart_ctl_pkg::IE_MODEM];
    assign pend[6] = (xoff_flag_q || spec_flag_q)
                     && interrupt_enable_q[uart_ctl_pkg::IE_SWFLOW];
    assign pend[7] = eng.cts_inact  && interrupt_enable_q[uart_ctl_pkg::IE_CTS_DSR];
    assign pend[8] = eng.rts_inact  && interrupt_enable_q[uart_ctl_pkg::IE_RTS_DTR];

    irq_priority u_prio (
        .pend (pend),
        .code (code)
    );

    // ------------------------------------------------------------
    // identification register and interrupt output
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!rstn || soft_rst) begin
            interrupt_source_id_q <= uart_ctl_pkg::ID_RESET;
            irq_n_q               <= 1'b1;
        end else begin
            interrupt_source_id_q <= {{2{fifo_en_q}}, code};
            irq_n_q               <= !(|pend);
        end
    end

    // ------------------------------------------------------------
    // register read path
    // ------------------------------------------------------------
    // unmapped or write-only offsets read as zero
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd && reg_addr == uart_ctl_pkg::OFF_INT_ENABLE
                     && !dlab) begin
            reg_rdata_q <= interrupt_enable_q;
        end else if (reg_rd && reg_addr == uart_ctl_pkg::OFF_INT_ENABLE
                     && dlab
                     && line_control != uart_ctl_pkg::LC_ENH_ACCESS) begin
            reg_rdata_q <= baud_divisor_high_q;
        end else if (rd_id) begin
            reg_rdata_q <= interrupt_source_id_q;
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // sleep control
    // ------------------------------------------------------------
    uart_ctl_pkg::power_state_t pwr_q;
    logic                       may_sleep;
    logic                       wake;

    assign may_sleep = interrupt_enable_q[uart_ctl_pkg::IE_SLEEP] && enh
                       && !(|pend) && !modem_toggle && rx_idle
                       && eng.tx_empty && eng.rx_empty;
    assign wake      = modem_toggle || !rx_idle || hold_write;

    // the stop request goes to the oscillator; wake terms are the synchronised pins and hold_write
    always_ff @(posedge mclk) begin
        if (!rstn || soft_rst) begin
            pwr_q <= uart_ctl_pkg::PWR_AWAKE;
        end else begin
            case (pwr_q)
                uart_ctl_pkg::PWR_AWAKE:
                    if (may_sleep && !hold_write) begin
                        pwr_q <= uart_ctl_pkg::PWR_ASLEEP;
                    end
                uart_ctl_pkg::PWR_ASLEEP:
                    if (wake) begin
                        pwr_q <= uart_ctl_pkg::PWR_AWAKE;
                    end
                default: pwr_q <= uart_ctl_pkg::PWR_AWAKE;
            endcase
        end
    end

    assign osc_stop_q = (pwr_q == uart_ctl_pkg::PWR_ASLEEP);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_tx_clr_write;
        wr_fs && reg_wdata[uart_ctl_pkg::FS_TX_CLR] && !soft_rst;
    endsequence
    sequence s_pulse_tx;
        tx_fifo_clr_q ##1 !tx_fifo_clr_q;
    endsequence

    chk_ie_upper_lock: assert property (
        wr_ie && !enh && !soft_rst |=> $stable(interrupt_enable_q[7:4]))
        else $error("enable upper nibble changed without enhanced mode");
    chk_div_soft_keep: assert property (
        !wr_div |=> $stable(baud_divisor_high_q))
        else $error("divisor high changed without a write");
    chk_id_pending_low: assert property (
        (|pend) && !soft_rst |=> !interrupt_source_id_q[0] && !irq_n_q)
        else $error("pending source not shown in id bit 0");
    chk_tx_clear_pulse: assert property (
        s_tx_clr_write |=> s_pulse_tx)
        else $error("tx fifo clear not a single pulse");
    chk_rx_clear_pulse: assert property (
        wr_fs && reg_wdata[uart_ctl_pkg::FS_RX_CLR] && !soft_rst
        |=> rx_fifo_clr_q ##1 !rx_fifo_clr_q)
        else $error("rx fifo clear not a single pulse");
    chk_sleep_entry_cond: assert property (
        $rose(osc_stop_q) |-> $past(may_sleep))
        else $error("sleep entered while conditions unmet");
    chk_sleep_wake_rx: assert property (
        osc_stop_q && !rx_idle && !soft_rst |=> !osc_stop_q)
        else $error("rx low did not wake the channel");
    chk_line_hidden: assert property (
        !interrupt_enable_q[uart_ctl_pkg::IE_LINE] && !wr_ie
        |=> interrupt_source_id_q[5:0] != uart_ctl_pkg::ID_LINE)
        else $error("disabled line status reported");
    chk_tx_trig_lock: assert property (
        wr_fs && !enh && !soft_rst |=> $stable(tx_sel_q))
        else $error("tx trigger changed without enhanced mode");
    chk_special_clear: assert property (
        rd_id && !eng.spec_det && !soft_rst |=> !spec_flag_q)
        else $error("special character flag survived id read");

endmodule
`default_nettype wire

// ===== dv/host_model.sv
// host controller model driving the register strobes
`timescale 1ns/1ps
`default_nettype none
module host_model (
    // clock and answer
    input  wire logic       mclk,
    input  wire logic [7:0] reg_rdata_q,
    // register strobes
    output logic      [3:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata
);
    // idle strobes from time zero
    initial begin
        reg_addr  = 4'h0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_wdata = 8'h00;
    end
    // one byte a strobe; strobe lasts exactly one cycle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
        reg_wdata <= ~d; // stale data must not look valid
    endtask
    // answer is registered, taken the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata_q;
    endtask
endmodule
`default_nettype wire

// ===== dv/test_uart_irq_fifo_control.sv
// self-checking bench for the uart interrupt and fifo control slice
`timescale 1ns/1ps
`default_nettype none
module test_uart_irq_fifo_control;
    typedef struct packed {
        logic [7:0]  ie;
        logic [11:0] st;
        logic [5:0]  id;
    } row_t;
    logic mclk, rstn, soft_rst, reg_wr, reg_rd, hold_write, rx_pin;
    logic [3:0] reg_addr, modem_pins;
    logic [7:0] reg_wdata, reg_rdata_q, line_ctl, enh_feat, v;
    logic [7:0] interrupt_enable_q, baud_divisor_high_q, interrupt_source_id_q;
    logic fifo_en_q, tx_fifo_clr_q, rx_fifo_clr_q, irq_n_q, osc_stop_q;
    logic [6:0] rx_trig_q, tx_trig_q, rx_lvl, tx_fr;
    uart_ctl_pkg::engine_status_t eng;
    int n_errors, check_count;
    logic [6:0] rxt [4] = '{7'h08, 7'h10, 7'h38, 7'h3c};
    logic [6:0] txt [4] = '{7'h08, 7'h10, 7'h20, 7'h38};
    row_t rows [12] = '{
        '{8'hff, 12'h003, 6'h01},
        '{8'hff, 12'hc03, 6'h06},
        '{8'hff, 12'h403, 6'h0c},
        '{8'hff, 12'h002, 6'h04},
        '{8'hff, 12'h203, 6'h02},
        '{8'hff, 12'h103, 6'h00},
        '{8'hff, 12'h083, 6'h30},
        '{8'hff, 12'h00b, 6'h20},
        '{8'hff, 12'h007, 6'h20},
        '{8'h7f, 12'h00b, 6'h01},
        '{8'hfb, 12'h803, 6'h01},
        '{8'hfd, 12'h203, 6'h01}
    };
    host_model host_u (.mclk, .reg_rdata_q, .reg_addr, .reg_wr, .reg_rd,
                       .reg_wdata);
    uart_irq_fifo_control dut_u (.mclk, .rstn, .soft_rst, .reg_addr, .reg_wr,
        .reg_rd, .reg_wdata, .reg_rdata_q, .line_control(line_ctl),
        .enhanced_feature(enh_feat), .eng, .rx_level(rx_lvl), .tx_free(tx_fr),
        .hold_write, .rx_pin, .modem_pins, .interrupt_enable_q,
        .baud_divisor_high_q, .interrupt_source_id_q, .fifo_en_q, .rx_trig_q,
        .tx_trig_q, .tx_fifo_clr_q, .rx_fifo_clr_q, .irq_n_q, .osc_stop_q);
    // clock, 25 ns period
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic chk(input logic [7:0] s, input logic [7:0] e);
        check_count++;
        if (s !== e) begin
            n_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic stop_test();
        $display("errors=%0d checks=%0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic stp(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // one-cycle engine pulse on top of the idle status
    task automatic pulse(input logic [11:0] p);
        @(posedge mclk);
        eng <= p;
        @(posedge mclk);
        eng <= 12'h003;
        stp(2);
    endtask
    // bounded wait for sleep; a miss ends the run
    task automatic wsleep();
        for (int k = 0; k < 10 && osc_stop_q !== 1'b1; k++) stp(1);
        chk({7'h0, osc_stop_q}, 8'h01);
        if (osc_stop_q !== 1'b1) stop_test();
    endtask
    // main sequence
    initial begin
        {rstn, soft_rst, hold_write, line_ctl, enh_feat} = '0;
        {n_errors, check_count} = '0;
        {rx_pin, modem_pins} = 5'h1f; // pins idle high, no edge after reset
        {rx_lvl, tx_fr} = {7'h01, 7'h00};
        eng = 12'h003;
        stp(5);
        rstn <= 1'b1;
        stp(1);
        chk(interrupt_enable_q, 8'h00);
        chk(baud_divisor_high_q, 8'h00);
        host_u.rd(4'h2, v);
        chk(v, 8'h01);
        // divisor high behind latch select, hidden at bf
        line_ctl <= 8'h80;
        host_u.wr(4'h1, 8'ha5);
        host_u.rd(4'h1, v);
        chk(v, 8'ha5);
        chk(interrupt_enable_q, 8'h00);
        line_ctl <= 8'hbf;
        host_u.wr(4'h1, 8'h3c);
        host_u.rd(4'h1, v);
        chk(v, 8'h00);
        line_ctl <= 8'h00;
        host_u.wr(4'h1, 8'hff);
        stp(1);
        chk(interrupt_enable_q, 8'h0f);
        soft_rst <= 1'b1;
        stp(1);
        soft_rst <= 1'b0;
        stp(1);
        chk(baud_divisor_high_q, 8'ha5);
        chk(interrupt_enable_q, 8'h00);
        enh_feat <= 8'h10;
        foreach (rows[i]) begin
            host_u.wr(4'h1, rows[i].ie);
            eng <= rows[i].st;
            stp(2);
            chk(interrupt_source_id_q, {2'b00, rows[i].id});
            chk({7'h0, irq_n_q}, {7'h0, rows[i].id == 6'h01});
            host_u.rd(4'h2, v);
            chk(v, {2'b00, rows[i].id});
        end
        // flow flag: xoff cleared by xon, special cleared by read
        eng <= 12'h003;
        host_u.wr(4'h1, 8'h20);
        pulse(12'h043);
        chk(interrupt_source_id_q, 8'h10);
        pulse(12'h023);
        chk(interrupt_source_id_q, 8'h01);
        pulse(12'h013);
        host_u.rd(4'h2, v);
        chk(v, 8'h10);
        stp(1);
        chk(interrupt_source_id_q, 8'h01);
        for (int i = 0; i < 4; i++) begin
            host_u.wr(4'h2, {i[1:0], i[1:0], 4'h1});
            stp(1);
            chk({1'b0, rx_trig_q}, {1'b0, rxt[i]});
            chk({1'b0, tx_trig_q}, {1'b0, txt[i]});
        end
        // fifo mode: tx ready above trigger, rx data from trigger on
        host_u.wr(4'h1, 8'h03);
        tx_fr <= 7'h39;
        stp(2);
        chk(interrupt_source_id_q, 8'hc2);
        tx_fr <= 7'h38;
        stp(2);
        chk(interrupt_source_id_q, 8'hc1);
        eng <= 12'h002;
        rx_lvl <= 7'h3b;
        stp(2);
        chk(interrupt_source_id_q, 8'hc1);
        rx_lvl <= 7'h3c;
        stp(2);
        chk(interrupt_source_id_q, 8'hc4);
        eng <= 12'h003;
        host_u.rd(4'h2, v);
        chk(v, 8'hc1);
        enh_feat <= 8'h00;
        host_u.wr(4'h2, 8'h05);
        #1;
        chk({7'h0, tx_fifo_clr_q}, 8'h01);
        stp(1);
        chk({7'h0, tx_fifo_clr_q}, 8'h00);
        chk({1'b0, tx_trig_q}, 8'h38);
        host_u.wr(4'h2, 8'h03);
        #1;
        chk({7'h0, rx_fifo_clr_q}, 8'h01);
        stp(1);
        chk({7'h0, rx_fifo_clr_q}, 8'h00);
        host_u.wr(4'h2, 8'h00);
        stp(1);
        chk({fifo_en_q, rx_trig_q}, 8'h01);
        // sleep entry and the three wake causes
        enh_feat <= 8'h10;
        host_u.wr(4'h1, 8'h10);
        wsleep();
        @(posedge mclk);
        hold_write <= 1'b1;
        @(posedge mclk);
        hold_write <= 1'b0;
        #1;
        chk({7'h0, osc_stop_q}, 8'h00);
        wsleep();
        rx_pin <= 1'b0;
        stp(6);
        chk({7'h0, osc_stop_q}, 8'h00);
        rx_pin <= 1'b1;
        host_u.wr(4'h1, 8'h11);
        eng <= 12'h002;
        stp(8);
        chk({7'h0, osc_stop_q}, 8'h00);
        // modem toggle wakes; awake for one cycle only, then asleep again
        eng <= 12'h003;
        wsleep();
        modem_pins <= 4'he;
        stp(3);
        chk({7'h0, osc_stop_q}, 8'h00);
        rstn <= 1'b0;
        stp(3);
        rstn <= 1'b1;
        stp(1);
        chk(baud_divisor_high_q, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
